// File: rtl/branch_skip_defs.vh
// Constants for the branch and skip condition unit.
// Assumes inclusion by bare name from files under rtl/.
`ifndef BRANCH_SKIP_DEFS_VH
`define BRANCH_SKIP_DEFS_VH

// Widths
`define PC_W             16
`define OFS_W            7

// Operation select codes
`define OP_NONE                4'h0
`define OP_SKIP_IF_REG_BIT_ONE 4'h1
`define OP_SKIP_IF_IO_BIT_ZERO 4'h2
`define OP_SKIP_IF_IO_BIT_ONE  4'h3
`define OP_BRANCH_ON_FLAG_ONE  4'h4
`define OP_BRANCH_ON_FLAG_ZERO 4'h5
`define OP_BRANCH_IF_EQUAL     4'h6
`define OP_BRANCH_IF_UNEQUAL   4'h7
`define OP_BRANCH_IF_CARRY_ONE 4'h8
`define OP_BRANCH_IF_CARRY_ZERO 4'h9
`define OP_BRANCH_IF_UNSIGNED_GE 4'ha
`define OP_BRANCH_IF_NEGATIVE  4'hb

// Status flag bit positions
`define FLAG_CARRY       3'h0
`define FLAG_ZERO        3'h1
`define FLAG_NEGATIVE    3'h2

// Register byte offsets
`define REG_CTRL         4'h0
`define REG_PC           4'h4
`define REG_STATUS       4'h8
`define REG_TAKEN_CNT    4'hc

// Field positions
`define CTRL_ENABLE_BIT  0
`define ST_BUSY_BIT      0
`define ST_TAKEN_BIT     1
`define ST_SKIP_BIT      2
`define ST_CYC_LSB       4
`define ST_CYC_MSB       5

// Reset values
`define CTRL_RESET       1'b1
`define PC_RESET         16'h0000

// Step counts in program words
`define PC_STEP_NORMAL   16'h0001
`define PC_STEP_SKIP1    16'h0002
`define PC_STEP_SKIP2    16'h0003

`endif

// File: rtl/bit_select8.v
// Picks one bit out of an eight-bit value.
// Assumes the select comes from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module bit_select8 (
  // Operand
  input  wire [7:0] value,
  input  wire [2:0] sel,
  // Result
  output wire       bit_out
);

  assign bit_out = value[sel];

endmodule

`default_nettype wire

// File: rtl/branch_skip_condition_unit.v
// Condition test and program counter update for skip and branch operations.
// Assumes the fetch side presents decoded operations with operands on clk_sys.
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "branch_skip_defs.vh"

module branch_skip_condition_unit (
  // Clock and reset
  input  wire                 clk_sys,
  input  wire                 rst_n,
  // Operation issue
  input  wire                 op_valid,
  output wire                 op_ready,
  input  wire [3:0]           op_code,
  input  wire [7:0]           reg_value,
  input  wire [7:0]           io_value,
  input  wire [2:0]           bit_index,
  input  wire [2:0]           flag_index,
  input  wire [`OFS_W-1:0]    offset_k,
  input  wire                 next_is_two_word,
  // Status flags from the ALU
  input  wire [7:0]           status_flags_register,
  output wire                 flags_write_en,
  // Program counter
  output wire [`PC_W-1:0]     pc_value,
  output reg                  pc_update,
  output reg                  op_done,
  output reg                  op_taken,
  // Avalon-MM slave
  input  wire [3:0]           address,
  input  wire                 read,
  input  wire                 write,
  input  wire [31:0]          writedata,
  output reg  [31:0]          readdata,
  output wire                 waitrequest
);

  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_WAIT1 = 4'b0010;
  localparam [3:0] ST_WAIT2 = 4'b0100;
  localparam [3:0] ST_FIN   = 4'b1000;

  reg  [3:0]        state_reg;
  reg  [3:0]        state_next;
  reg  [`PC_W-1:0]  pc_reg;
  reg  [`PC_W-1:0]  target_reg;
  reg  [`PC_W-1:0]  target_next;
  reg               taken_reg;
  reg               skip_kind_reg;
  reg  [1:0]        cycles_reg;
  reg               enable_reg;
  reg  [31:0]       taken_count_reg;
  reg               resp_reg;
  reg               rst_meta_n_reg;
  reg               rst_sync_n_reg;
  reg  [31:0]       status_word;

  wire              reg_bit;
  wire              io_bit;
  wire              flag_bit;
  wire              accept;
  wire              bus_req;
  wire              bus_write;
  wire              bus_read;
  wire [`PC_W-1:0]  pc_plus1;
  wire [`PC_W-1:0]  offset_ext;
  wire [`PC_W-1:0]  skip_target;
  wire [`PC_W-1:0]  branch_target;
  wire              pc_load;
  wire              done_taken;

  reg               cond;
  reg               is_skip;
  reg               is_branch;

  bit_select8 u_reg_bit (
    .value   (reg_value),
    .sel     (bit_index),
    .bit_out (reg_bit)
  );

  bit_select8 u_io_bit (
    .value   (io_value),
    .sel     (bit_index),
    .bit_out (io_bit)
  );

  bit_select8 u_flag_bit (
    .value   (status_flags_register),
    .sel     (flag_index),
    .bit_out (flag_bit)
  );

  // Release retimed by two stages; assertion stays immediate
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_n_reg <= 1'b1;
      rst_sync_n_reg <= rst_meta_n_reg;
    end
  end

  // None of these operations alter status flags
  assign flags_write_en = 1'b0;

  assign pc_value = pc_reg;
  // Refused until the retimed reset lets go, else an offer would be lost
  assign op_ready = enable_reg & state_reg[0] & rst_sync_n_reg;
  assign accept   = op_valid & op_ready;

  assign pc_plus1   = pc_reg + `PC_STEP_NORMAL;
  assign offset_ext = {{(`PC_W-`OFS_W){offset_k[`OFS_W-1]}}, offset_k};
  assign skip_target = next_is_two_word ? pc_reg + `PC_STEP_SKIP2
                                        : pc_reg + `PC_STEP_SKIP1;
  assign branch_target = pc_plus1 + offset_ext;

  // Condition per operation
  always @* begin
    cond      = 1'b0;
    is_skip   = 1'b0;
    is_branch = 1'b0;
    case (op_code)
      `OP_SKIP_IF_REG_BIT_ONE: begin
        is_skip = 1'b1;
        cond    = reg_bit;
      end
      `OP_SKIP_IF_IO_BIT_ZERO: begin
        is_skip = 1'b1;
        cond    = ~io_bit;
      end
      `OP_SKIP_IF_IO_BIT_ONE: begin
        is_skip = 1'b1;
        cond    = io_bit;
      end
      `OP_BRANCH_ON_FLAG_ONE: begin
        is_branch = 1'b1;
        cond      = flag_bit;
      end
      `OP_BRANCH_ON_FLAG_ZERO: begin
        is_branch = 1'b1;
        cond      = ~flag_bit;
      end
      `OP_BRANCH_IF_EQUAL: begin
        is_branch = 1'b1;
        cond      = status_flags_register[`FLAG_ZERO];
      end
      `OP_BRANCH_IF_UNEQUAL: begin
        is_branch = 1'b1;
        cond      = ~status_flags_register[`FLAG_ZERO];
      end
      `OP_BRANCH_IF_CARRY_ONE: begin
        is_branch = 1'b1;
        cond      = status_flags_register[`FLAG_CARRY];
      end
      `OP_BRANCH_IF_CARRY_ZERO,
      `OP_BRANCH_IF_UNSIGNED_GE: begin
        is_branch = 1'b1;
        cond      = ~status_flags_register[`FLAG_CARRY];
      end
      `OP_BRANCH_IF_NEGATIVE: begin
        is_branch = 1'b1;
        cond      = status_flags_register[`FLAG_NEGATIVE];
      end
      default: begin
        cond = 1'b0;
      end
    endcase
  end

  // Target chosen at issue; unknown codes just step one word
  always @* begin
    target_next = pc_plus1;
    if (is_skip && cond) begin
      target_next = skip_target;
    end else if (is_branch && cond) begin
      target_next = branch_target;
    end
  end

  // Sequencer: extra cycles stand for skipped words or the branch refill
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          if (is_skip && cond && next_is_two_word) begin
            state_next = ST_WAIT2;
          end else if (cond && (is_skip || is_branch)) begin
            state_next = ST_WAIT1;
          end else begin
            state_next = ST_FIN;
          end
        end
      end
      ST_WAIT2: begin
        state_next = ST_WAIT1;
      end
      ST_WAIT1: begin
        state_next = ST_FIN;
      end
      ST_FIN: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      state_reg     <= ST_IDLE;
      target_reg    <= `PC_RESET;
      taken_reg     <= 1'b0;
      skip_kind_reg <= 1'b0;
      cycles_reg    <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        target_reg    <= target_next;
        taken_reg     <= cond & (is_skip | is_branch);
        skip_kind_reg <= is_skip;
        cycles_reg    <= 2'h1;
      end else if (state_reg[1] || state_reg[2]) begin
        cycles_reg <= cycles_reg + 2'h1;
      end
    end
  end

  // Completion pulses; PC moves as the operation finishes
  always @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      pc_update <= 1'b0;
      op_done   <= 1'b0;
      op_taken  <= 1'b0;
    end else begin
      pc_update <= state_reg[3];
      op_done   <= state_reg[3];
      op_taken  <= done_taken;
    end
  end

  // Avalon-MM: one wait state on every access
  assign bus_req     = read | write;
  assign waitrequest = bus_req & ~resp_reg;
  assign bus_write   = write & resp_reg;
  assign bus_read    = read & ~resp_reg;
  assign pc_load     = bus_write & (address == `REG_PC) & state_reg[0] & ~accept;
  assign done_taken  = state_reg[3] & taken_reg;

  always @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      resp_reg <= 1'b0;
    end else begin
      resp_reg <= bus_req & ~resp_reg;
    end
  end

  // PC: software load only while idle, so a running operation wins
  always @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      pc_reg <= `PC_RESET;
    end else if (state_reg[3]) begin
      pc_reg <= target_reg;
    end else if (pc_load) begin
      pc_reg <= writedata[`PC_W-1:0];
    end
  end

  always @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      enable_reg <= `CTRL_RESET;
    end else if (bus_write && address == `REG_CTRL) begin
      enable_reg <= writedata[`CTRL_ENABLE_BIT];
    end
  end

  // Taken counter: a count in the clearing cycle survives as one
  always @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      taken_count_reg <= 32'h0000_0000;
    end else if (bus_write && address == `REG_TAKEN_CNT) begin
      taken_count_reg <= {31'h0000_0000, done_taken};
    end else if (done_taken) begin
      taken_count_reg <= taken_count_reg + 32'h0000_0001;
    end
  end

  // Status fields placed by their defined positions
  always @* begin
    status_word = 32'h0000_0000;
    status_word[`ST_BUSY_BIT]            = ~state_reg[0];
    status_word[`ST_TAKEN_BIT]           = taken_reg;
    status_word[`ST_SKIP_BIT]            = skip_kind_reg;
    status_word[`ST_CYC_MSB:`ST_CYC_LSB] = cycles_reg;
  end

  always @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      readdata <= 32'h0000_0000;
    end else if (bus_read) begin
      if (address == `REG_CTRL) begin
        readdata <= {31'h0000_0000, enable_reg};
      end else if (address == `REG_PC) begin
        readdata <= {16'h0000, pc_reg};
      end else if (address == `REG_STATUS) begin
        readdata <= status_word;
      end else if (address == `REG_TAKEN_CNT) begin
        readdata <= taken_count_reg;
      end else begin
        readdata <= 32'h0000_0000;
      end
    end
  end

endmodule

`default_nettype wire

// File: verif/bsc_expect.svh
// Expected outcome of one operation: {taken, next program counter}.
// Assumes flags carry, zero, negative sit in bits 0, 1, 2.
`ifndef BSC_EXPECT_SVH
`define BSC_EXPECT_SVH
function automatic logic [16:0] next_pc(input logic [3:0] c, input logic [7:0] rv, iv, fl,
  input logic [2:0] b, s, input logic [6:0] k, input logic tw, input logic [15:0] pc);
  logic t;
  case (c)
    4'h1: t = rv[b];
    4'h2: t = !iv[b];
    4'h3: t = iv[b];
    4'h4: t = fl[s];
    4'h5: t = !fl[s];
    4'h6: t = fl[1];
    4'h7: t = !fl[1];
    4'h8: t = fl[0];
    4'h9, 4'ha: t = !fl[0];
    4'hb: t = fl[2];
    default: t = 1'b0;
  endcase
  if (!t) return {1'b0, pc + 16'h0001};
  if (c < 4'h4) return {1'b1, pc + (tw ? 16'h0003 : 16'h0002)};
  return {1'b1, pc + 16'h0001 + {{9{k[6]}}, k}};
endfunction
`endif

// File: verif/bsc_properties.sv
// Checker for operation latency, target and flag behaviour.
// Assumes it is bound to the unit and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module bsc_checker (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // Operation issue
  input wire logic       op_valid,
  input wire logic       op_ready,
  input wire logic [3:0] op_code,
  input wire logic [7:0] reg_value,
  input wire logic [7:0] io_value,
  input wire logic [2:0] bit_index,
  input wire logic [2:0] flag_index,
  input wire logic [6:0] offset_k,
  input wire logic       next_is_two_word,
  input wire logic [7:0] status_flags_register,
  // Results
  input wire logic       flags_write_en,
  input wire logic [15:0] pc_value,
  input wire logic       pc_update,
  input wire logic       op_done,
  input wire logic       op_taken
);
  logic        acc;
  logic        hit;
  logic [16:0] nx;
  logic [16:0] exp_reg;
  assign acc = op_valid && op_ready;
  // Own outcome model, so the bench's guarded header is not needed here
  always_comb begin
    case (op_code)
      4'h1: hit = reg_value[bit_index];
      4'h2: hit = !io_value[bit_index];
      4'h3: hit = io_value[bit_index];
      4'h4: hit = status_flags_register[flag_index];
      4'h5: hit = !status_flags_register[flag_index];
      4'h6: hit = status_flags_register[1];
      4'h7: hit = !status_flags_register[1];
      4'h8: hit = status_flags_register[0];
      4'h9, 4'ha: hit = !status_flags_register[0];
      4'hb: hit = status_flags_register[2];
      default: hit = 1'b0;
    endcase
    if (!hit) nx = {1'b0, pc_value + 16'h0001};
    else if (op_code < 4'h4) nx = {1'b1, pc_value + (next_is_two_word ? 16'h0003 : 16'h0002)};
    else nx = {1'b1, pc_value + 16'h0001 + {{9{offset_k[6]}}, offset_k}};
  end
  // Outcome frozen at accept, since operands are gone by completion
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) exp_reg <= 17'h0_0000;
    else if (acc) exp_reg <= nx;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_quiet2;
    !op_done ##1 !op_done;
  endsequence
  sequence s_quiet3;
    s_quiet2 ##1 !op_done;
  endsequence
  a_flags_untouched: assert property (flags_write_en == 1'b0)
    else $error("flag write enable raised");
  a_done_pc_target: assert property (op_done |-> pc_value == exp_reg[15:0])
    else $error("wrong program counter at completion");
  a_done_taken_match: assert property (op_done |-> op_taken == exp_reg[16])
    else $error("taken indication wrong");
  a_done_with_update: assert property (op_done |-> pc_update ##1 !op_done)
    else $error("completion pulse malformed");
  a_busy_not_ready: assert property (acc |=> !op_ready)
    else $error("ready while busy");
  a_untaken_latency: assert property (acc && !nx[16] |=> !op_done ##1 op_done)
    else $error("untaken completion late or early");
  a_branch_latency: assert property (acc && nx[16] && op_code > 4'h3 |=> s_quiet2 ##1 op_done)
    else $error("taken branch completion wrong");
  a_skip_one_latency: assert property (acc && nx[16] && op_code < 4'h4 && !next_is_two_word
    |=> s_quiet2 ##1 op_done)
    else $error("one-word skip completion wrong");
  a_skip_two_latency: assert property (acc && nx[16] && op_code < 4'h4 && next_is_two_word
    |=> s_quiet3 ##1 op_done)
    else $error("two-word skip completion wrong");
endmodule
bind branch_skip_condition_unit bsc_checker u_bsc_checker (.clk_sys, .rst_n, .op_valid,
  .op_ready, .op_code, .reg_value, .io_value, .bit_index, .flag_index, .offset_k,
  .next_is_two_word, .status_flags_register, .flags_write_en, .pc_value, .pc_update,
  .op_done, .op_taken);
`default_nettype wire

// File: verif/fetch_model.sv
// Fetch side model: offers one decoded operation at a time.
// Assumes the unit takes an offer at an edge with op_ready high.
`timescale 1ns/1ns
`default_nettype none
module fetch_model (
  // Clock and handshake
  input wire logic        clk_sys,
  input wire logic        op_ready,
  input wire logic        op_done,
  output var logic        op_valid,
  // Operands
  output var logic [3:0]  op_code,
  output var logic [7:0]  reg_value,
  output var logic [7:0]  io_value,
  output var logic [7:0]  status_flags_register,
  output var logic [2:0]  bit_index,
  output var logic [2:0]  flag_index,
  output var logic [6:0]  offset_k,
  output var logic        next_is_two_word
);
  initial begin
    op_valid = 1'b0;
    {op_code, reg_value, io_value, status_flags_register} = 28'h000_0000;
    {bit_index, flag_index, offset_k, next_is_two_word} = 14'h0000;
  end
  // Operands inverted after accept so stale values never look valid
  task automatic issue(input logic [3:0] c, input logic [7:0] rv, iv, fl,
    input logic [2:0] b, s, input logic [6:0] k, input logic tw);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    {op_code, reg_value, io_value, status_flags_register} <= {c, rv, iv, fl};
    {bit_index, flag_index, offset_k, next_is_two_word} <= {b, s, k, tw};
    do @(posedge clk_sys); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    {op_code, reg_value, io_value, status_flags_register} <= ~{c, rv, iv, fl};
    {bit_index, flag_index, offset_k, next_is_two_word} <= ~{b, s, k, tw};
    do @(posedge clk_sys); while (op_done !== 1'b1);
  endtask
endmodule
`default_nettype wire

// File: verif/branch_skip_condition_unit_tb.sv
// Testbench: register access over the bus, then operation codes 1 to 11 and one unknown code.
// Assumes the fetch model drives the operation port.
`timescale 1ns/1ns
`default_nettype none
module branch_skip_condition_unit_tb;
  `include "bsc_expect.svh"
  logic        clk_sys, rst_n, read, write, waitrequest, flags_write_en;
  logic        op_valid, op_ready, next_is_two_word, pc_update, op_done, op_taken;
  logic [3:0]  address, op_code;
  logic [7:0]  reg_value, io_value, status_flags_register;
  logic [2:0]  bit_index, flag_index;
  logic [6:0]  offset_k;
  logic [15:0] pc_value;
  logic [31:0] writedata, readdata;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  branch_skip_condition_unit u_branch_skip_condition_unit (.clk_sys, .rst_n, .op_valid,
    .op_ready, .op_code, .reg_value, .io_value, .bit_index, .flag_index, .offset_k,
    .next_is_two_word, .status_flags_register, .flags_write_en, .pc_value, .pc_update,
    .op_done, .op_taken, .address, .read, .write, .writedata, .readdata, .waitrequest);
  fetch_model u_fetch_model (.clk_sys, .op_ready, .op_done, .op_valid, .op_code,
    .reg_value, .io_value, .status_flags_register, .bit_index, .flag_index, .offset_k,
    .next_is_two_word);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_sys);
    {read, write, address, writedata} <= {!w, w, a, d};
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    q = readdata;
    {read, write} <= 2'h0;
  endtask
  initial begin
    logic [31:0] q;
    logic [16:0] e;
    logic [15:0] pc;
    logic [7:0]  m;
    logic [6:0]  k;
    logic [31:0] tk;
    logic [1:0]  cy;
    rst_n = 1'b0;
    {read, write, address, writedata} = 38'h00_0000_0000;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0000_0000, q);
    check("ctrl", q, 32'h0000_0001);
    bus(1'b0, 4'h4, 32'h0000_0000, q);
    check("pc", q, 32'h0000_0000);
    bus(1'b0, 4'h2, 32'h0000_0000, q);
    check("unmapped", q, 32'h0000_0000);
    $display("test reset done");
    pc = 16'h0100;
    tk = 32'h0000_0000;
    bus(1'b1, 4'h4, {16'h0000, pc}, q);
    // Both outcomes per code 1 to 11, untaken only for code 12; offset at both signed extremes
    for (int c = 1; c < 13; c++) begin
      for (int p = 0; p < 2; p++) begin
        m = 8'h01 << c[2:0];
        if (p == 0) m = ~m;
        k = p ? 7'h3f : 7'h40;
        e = next_pc(4'(c), m, m, m, 3'(c), 3'(c), k, p[0], pc);
        u_fetch_model.issue(4'(c), m, m, m, 3'(c), 3'(c), k, p[0]);
        check("pc", {16'h0000, pc_value}, {16'h0000, e[15:0]});
        check("taken", {31'h0000_0000, op_taken}, {31'h0000_0000, e[16]});
        pc = e[15:0];
        tk = tk + {31'h0000_0000, e[16]};
        cy = !e[16] ? 2'h1 : (c < 4 && p == 1) ? 2'h3 : 2'h2;
        bus(1'b0, 4'h8, 32'h0000_0000, q);
        check("status", q, {26'h000_0000, cy, 1'b0, c < 4, e[16], 1'b0});
      end
    end
    $display("test operations done");
    bus(1'b0, 4'hc, 32'h0000_0000, q);
    check("taken count", q, tk);
    bus(1'b1, 4'hc, 32'h0000_0000, q);
    bus(1'b0, 4'hc, 32'h0000_0000, q);
    check("count cleared", q, 32'h0000_0000);
    $display("test counter done");
    bus(1'b1, 4'h0, 32'h0000_0000, q);
    @(posedge clk_sys);
    check("ready off", {31'h0000_0000, op_ready}, 32'h0000_0000);
    bus(1'b1, 4'h0, 32'h0000_0001, q);
    $display("test disable done");
    final_report();
  end
endmodule
`default_nettype wire
